// ### csr_pkg.sv
// csr_pkg: offsets, field positions, reset values and keys of the core special register bank.
// used by csr_bank and the bench; nothing else is assumed.
package csr_pkg;
    localparam logic [3:0] OFS_KEY = 4'h4;
    localparam logic [3:0] OFS_DPAGE = 4'h8;
    localparam logic [3:0] OFS_XPAGE = 4'h9;
    localparam logic [3:0] OFS_YPAGE = 4'ha;
    localparam logic [3:0] OFS_ZPAGE = 4'hb;
    localparam logic [3:0] OFS_JPAGE = 4'hc;
    localparam logic [3:0] OFS_SPL = 4'hd;
    localparam logic [3:0] OFS_SPH = 4'he;
    localparam logic [3:0] OFS_FLAGS = 4'hf;
    localparam int FLAG_I = 7;
    localparam int FLAG_T = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_S = 4;
    localparam int FLAG_V = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] KEY_IOREG = 8'hd8;
    localparam logic [7:0] KEY_SPM = 8'h9d;
    localparam logic [2:0] GUARD_INSNS = 3'h4;
    localparam logic [2:0] KEY_INSNS = 3'h4;
endpackage

// ### csr_guard_if.sv
// csr_guard_if: carries the instruction-count guard signals between bank and guard.
// one clock domain; bank drives start/stop, guard returns active.
`timescale 1ns/1ps
`default_nettype none
interface csr_guard_if;
    logic start;
    logic stop;
    logic insn_done;
    logic active;
    modport bank (output start, output stop, output insn_done, input active);
    modport guard (input start, input stop, input insn_done, output active);
endinterface
`default_nettype wire

// ### csr_guard.sv
// csr_guard: counts retired instructions after a start pulse, ends early on stop.
// assumes insn_done is a one-cycle pulse per instruction on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module csr_guard #(
    parameter logic [2:0] COUNT = 3'h4
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset
    csr_guard_if.guard g // guard handshake
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    initial begin
        if (COUNT == 3'h0) $error("guard count must be nonzero");
    end
    always_comb begin
        cnt_nxt = cnt_r;
        if (g.start) begin
            cnt_nxt = COUNT;
        end else if (g.stop) begin
            cnt_nxt = 3'h0;
        end else if (g.insn_done && cnt_r != 3'h0) begin
            cnt_nxt = cnt_r - 3'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) cnt_r <= 3'h0;
        else cnt_r <= cnt_nxt;
    end
    assign g.active = (cnt_r != 3'h0);
endmodule
`default_nettype wire

// ### csr_bank.sv
// csr_bank: core special registers (page extenders, stack pointer, flags, change key).
// assumes execution logic on clk_sys drives one-cycle strobes and reads the outputs.
// Contract
// - jump page forms top byte above Z
// - unimplemented jump page bits read zero
// - stack pointer from low/high byte registers
// - reset loads stack pointer with SRAM top
// - low-byte write blocks interrupts four instructions
// - unimplemented stack pointer bits read zero
// - flag bit 7 gates every interrupt
// - interrupt entry never clears enable bit
// - enable change over bus adds wait
// - flag bit 6 is bit copy store
// - sign equals negative xor overflow
// - bit 5 records half carry
// - bit 3 records overflow
// - bits 2..0 record negative zero carry
// - matching key opens four-instruction window
// - data page forms top of address
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module csr_bank #(
    parameter int PAGE_BITS = 8,
    parameter int JUMP_BITS = 8,
    parameter int SP_BITS = 16,
    parameter logic [15:0] SRAM_TOP = 16'h3fff
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [3:0] reg_addr, // register offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    output logic reg_wait, // one-cycle wait on enable change
    input wire logic io_wr_any, // any other i/o memory write
    input wire logic insn_done, // one pulse per retired instruction
    input wire logic set_irq_insn, // set enable instruction
    input wire logic clear_irq_insn, // clear enable instruction
    input wire logic bit_store_insn, // copy bit into store
    input wire logic bit_store_val, // bit being stored
    input wire logic alu_upd, // alu result updates flags
    input wire logic [7:0] alu_mask, // which of bits 5 and 3..0 to update
    input wire logic alu_h, // half carry
    input wire logic alu_v, // overflow
    input wire logic alu_n, // negative
    input wire logic alu_z, // zero
    input wire logic alu_c, // carry
    input wire logic [15:0] z_ptr, // Z pointer
    input wire logic [15:0] x_ptr, // X pointer
    input wire logic [15:0] y_ptr, // Y pointer
    input wire logic [15:0] direct_op, // direct operand
    input wire logic sp_load, // stack push/pop update
    input wire logic [15:0] sp_load_val, // new stack pointer
    output logic [23:0] jump_addr, // extended jump target
    output logic [23:0] direct_addr, // extended direct address
    output logic [23:0] x_addr, // extended X address
    output logic [23:0] y_addr, // extended Y address
    output logic [23:0] z_addr, // extended Z address
    output logic [15:0] stack_ptr, // stack pointer
    output logic [7:0] cpu_flags, // status flags
    output logic bit_load_insn_val, // bit for bit load
    output logic irq_allow, // interrupts may be taken
    output logic key_ioreg_open, // protected i/o window open
    output logic key_spm_open // protected program window open
);
    logic [7:0] dpage_r, dpage_nxt, xpage_r, xpage_nxt;
    logic [7:0] ypage_r, ypage_nxt, zpage_r, zpage_nxt;
    logic [7:0] jpage_r, jpage_nxt;
    logic [15:0] sp_r, sp_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    logic key_io_r, key_io_nxt, key_spm_r, key_spm_nxt;
    logic [2:0] kcnt_r, kcnt_nxt;
    logic [7:0] jmask, pmask;
    logic [15:0] spmask;
    logic wr_key, wr_spl;
    csr_guard_if gi ();

    initial begin
        if (PAGE_BITS < 1 || PAGE_BITS > 8) $error("PAGE_BITS out of range");
        if (JUMP_BITS < 1 || JUMP_BITS > 8) $error("JUMP_BITS out of range");
        if (SP_BITS < 1 || SP_BITS > 16) $error("SP_BITS out of range");
    end

    assign pmask = 8'(({8'h0, 8'hff} >> (8 - PAGE_BITS)));
    assign jmask = 8'(({8'h0, 8'hff} >> (8 - JUMP_BITS)));
    assign spmask = 16'(({16'h0, 16'hffff} >> (16 - SP_BITS)));
    assign wr_key = reg_wr && reg_addr == csr_pkg::OFS_KEY;
    assign wr_spl = reg_wr && reg_addr == csr_pkg::OFS_SPL;

    // writes to other offsets of this bank count as i/o writes that end the guard
    assign gi.start = wr_spl;
    assign gi.stop = io_wr_any || (reg_wr && !wr_spl);
    assign gi.insn_done = insn_done;

    csr_guard #(.COUNT(csr_pkg::GUARD_INSNS)) u_guard (
        .clk_sys(clk_sys),
        .rst(rst),
        .g(gi)
    );

    always_comb begin
        dpage_nxt = dpage_r;
        xpage_nxt = xpage_r;
        ypage_nxt = ypage_r;
        zpage_nxt = zpage_r;
        jpage_nxt = jpage_r;
        sp_nxt = sp_r;
        flags_nxt = flags_r;
        wait_nxt = 1'b0;
        if (sp_load) sp_nxt = sp_load_val & spmask;
        if (set_irq_insn) flags_nxt[csr_pkg::FLAG_I] = 1'b1;
        if (clear_irq_insn) flags_nxt[csr_pkg::FLAG_I] = 1'b0;
        if (bit_store_insn) flags_nxt[csr_pkg::FLAG_T] = bit_store_val;
        if (alu_upd) begin
            if (alu_mask[csr_pkg::FLAG_H]) flags_nxt[csr_pkg::FLAG_H] = alu_h;
            if (alu_mask[csr_pkg::FLAG_V]) flags_nxt[csr_pkg::FLAG_V] = alu_v;
            if (alu_mask[csr_pkg::FLAG_N]) flags_nxt[csr_pkg::FLAG_N] = alu_n;
            if (alu_mask[csr_pkg::FLAG_Z]) flags_nxt[csr_pkg::FLAG_Z] = alu_z;
            if (alu_mask[csr_pkg::FLAG_C]) flags_nxt[csr_pkg::FLAG_C] = alu_c;
        end
        if (reg_wr) begin
            case (reg_addr)
                csr_pkg::OFS_DPAGE: dpage_nxt = reg_wdata & pmask;
                csr_pkg::OFS_XPAGE: xpage_nxt = reg_wdata & pmask;
                csr_pkg::OFS_YPAGE: ypage_nxt = reg_wdata & pmask;
                csr_pkg::OFS_ZPAGE: zpage_nxt = reg_wdata & pmask;
                csr_pkg::OFS_JPAGE: jpage_nxt = reg_wdata & jmask;
                csr_pkg::OFS_SPL: sp_nxt[7:0] = reg_wdata & spmask[7:0];
                csr_pkg::OFS_SPH: sp_nxt[15:8] = reg_wdata & spmask[15:8];
                csr_pkg::OFS_FLAGS: begin
                    flags_nxt = reg_wdata;
                    wait_nxt = reg_wdata[csr_pkg::FLAG_I] != flags_r[csr_pkg::FLAG_I];
                end
                default: ;
            endcase
        end
        // sign is derived, never stored on its own
        flags_nxt[csr_pkg::FLAG_S] = flags_nxt[csr_pkg::FLAG_N] ^ flags_nxt[csr_pkg::FLAG_V];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dpage_r <= csr_pkg::PAGE_RST;
            xpage_r <= csr_pkg::PAGE_RST;
            ypage_r <= csr_pkg::PAGE_RST;
            zpage_r <= csr_pkg::PAGE_RST;
            jpage_r <= csr_pkg::PAGE_RST;
            sp_r <= SRAM_TOP & spmask;
            flags_r <= csr_pkg::FLAGS_RST;
            wait_r <= 1'b0;
        end else begin
            dpage_r <= dpage_nxt;
            xpage_r <= xpage_nxt;
            ypage_r <= ypage_nxt;
            zpage_r <= zpage_nxt;
            jpage_r <= jpage_nxt;
            sp_r <= sp_nxt;
            flags_r <= flags_nxt;
            wait_r <= wait_nxt;
        end
    end

    // change key window: counts instructions, program window closes early on a data write
    always_comb begin
        key_io_nxt = key_io_r;
        key_spm_nxt = key_spm_r;
        kcnt_nxt = kcnt_r;
        if (wr_key && reg_wdata == csr_pkg::KEY_IOREG) begin
            key_io_nxt = 1'b1;
            key_spm_nxt = 1'b0;
            kcnt_nxt = csr_pkg::KEY_INSNS;
        end else if (wr_key && reg_wdata == csr_pkg::KEY_SPM) begin
            key_spm_nxt = 1'b1;
            key_io_nxt = 1'b0;
            kcnt_nxt = csr_pkg::KEY_INSNS;
        end else if (kcnt_r != 3'h0) begin
            if (insn_done) kcnt_nxt = kcnt_r - 3'h1;
            if (key_spm_r && (io_wr_any || reg_wr)) kcnt_nxt = 3'h0;
            if (kcnt_nxt == 3'h0) begin
                key_io_nxt = 1'b0;
                key_spm_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_io_r <= 1'b0;
            key_spm_r <= 1'b0;
            kcnt_r <= 3'h0;
        end else begin
            key_io_r <= key_io_nxt;
            key_spm_r <= key_spm_nxt;
            kcnt_r <= kcnt_nxt;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                csr_pkg::OFS_KEY: rdata_nxt = {6'h00, key_spm_r, key_io_r};
                csr_pkg::OFS_DPAGE: rdata_nxt = dpage_r;
                csr_pkg::OFS_XPAGE: rdata_nxt = xpage_r;
                csr_pkg::OFS_YPAGE: rdata_nxt = ypage_r;
                csr_pkg::OFS_ZPAGE: rdata_nxt = zpage_r;
                csr_pkg::OFS_JPAGE: rdata_nxt = jpage_r;
                csr_pkg::OFS_SPL: rdata_nxt = sp_r[7:0];
                csr_pkg::OFS_SPH: rdata_nxt = sp_r[15:8];
                csr_pkg::OFS_FLAGS: rdata_nxt = flags_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) rdata_r <= 8'h00;
        else rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;
    assign reg_wait = wait_r;
    assign jump_addr = {jpage_r, z_ptr};
    assign direct_addr = {dpage_r, direct_op};
    assign x_addr = {xpage_r, x_ptr};
    assign y_addr = {ypage_r, y_ptr};
    assign z_addr = {zpage_r, z_ptr};
    assign stack_ptr = sp_r;
    assign cpu_flags = flags_r;
    assign bit_load_insn_val = flags_r[csr_pkg::FLAG_T];
    // enable bit gates everything; stack and key windows hold interrupts off
    assign irq_allow = flags_r[csr_pkg::FLAG_I] && !gi.active && kcnt_r == 3'h0;
    assign key_ioreg_open = key_io_r;
    assign key_spm_open = key_spm_r;

    property p_sign;
        @(posedge clk_sys) disable iff (rst)
        cpu_flags[csr_pkg::FLAG_S] == (cpu_flags[csr_pkg::FLAG_N] ^ cpu_flags[csr_pkg::FLAG_V]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");

    property p_ien_gate;
        @(posedge clk_sys) disable iff (rst)
        !cpu_flags[csr_pkg::FLAG_I] |-> !irq_allow;
    endproperty
    a_ien_gate: assert property (p_ien_gate) else $error("irq allowed while disabled");

    property p_spl_guard;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == csr_pkg::OFS_SPL) |=> !irq_allow;
    endproperty
    a_spl_guard: assert property (p_spl_guard) else $error("irq after stack write");

    property p_wait;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == csr_pkg::OFS_FLAGS
            && reg_wdata[csr_pkg::FLAG_I] != cpu_flags[csr_pkg::FLAG_I])
            |=> reg_wait ##1 (!reg_wait
            // a second enable change right behind the first earns its own wait
            || $past(reg_wr && reg_addr == csr_pkg::OFS_FLAGS
            && reg_wdata[csr_pkg::FLAG_I] != cpu_flags[csr_pkg::FLAG_I]));
    endproperty
    a_wait: assert property (p_wait) else $error("wait state missing");

    property p_ien_hold;
        @(posedge clk_sys) disable iff (rst)
        (!set_irq_insn && !clear_irq_insn && !(reg_wr && reg_addr == csr_pkg::OFS_FLAGS))
            |=> $stable(cpu_flags[csr_pkg::FLAG_I]);
    endproperty
    a_ien_hold: assert property (p_ien_hold) else $error("enable changed by itself");

    property p_bst;
        @(posedge clk_sys) disable iff (rst)
        (bit_store_insn && !(reg_wr && reg_addr == csr_pkg::OFS_FLAGS))
            |=> bit_load_insn_val == $past(bit_store_val);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store lost");

    property p_jump;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == csr_pkg::OFS_JPAGE) |=> jump_addr[23:16] == ($past(reg_wdata) & jmask);
    endproperty
    a_jump: assert property (p_jump) else $error("jump page wrong");

    property p_key;
        @(posedge clk_sys) disable iff (rst)
        (wr_key && reg_wdata == csr_pkg::KEY_IOREG) |=> key_ioreg_open && !irq_allow;
    endproperty
    a_key: assert property (p_key) else $error("key window not open");

    property p_key_spm;
        @(posedge clk_sys) disable iff (rst)
        (wr_key && reg_wdata == csr_pkg::KEY_SPM) |=> key_spm_open && !key_ioreg_open && !irq_allow;
    endproperty
    a_key_spm: assert property (p_key_spm) else $error("program key window not open");

    // any data write ends the program window unless it is itself a fresh key
    property p_spm_close;
        @(posedge clk_sys) disable iff (rst)
        (key_spm_open && (io_wr_any || reg_wr)
            && !(wr_key && (reg_wdata == csr_pkg::KEY_IOREG || reg_wdata == csr_pkg::KEY_SPM)))
            |=> !key_spm_open;
    endproperty
    a_spm_close: assert property (p_spm_close) else $error("program window left open");

    property p_rsvd;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && (reg_addr < csr_pkg::OFS_KEY
            || (reg_addr > csr_pkg::OFS_KEY && reg_addr < csr_pkg::OFS_DPAGE)))
            |=> reg_rdata == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read nonzero");
endmodule
`default_nettype wire

// ### csr_core_model.sv
// csr_core_model: behavioural execution core facing the special register bank.
// retires instructions while run is high and produces add flags on go; one clock.
`timescale 1ns/1ps
`default_nettype none
module csr_core_model (
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset
    input wire logic run, // retire instructions while high
    input wire logic slow, // retire only every other cycle
    input wire logic go, // start one add
    input wire logic [7:0] op_a, // first addend
    input wire logic [7:0] op_b, // second addend
    output logic insn_done, // retire pulse
    output logic alu_upd, // flag update pulse
    output logic [4:0] alu_hvnzc // half carry, overflow, negative, zero, carry
);
    logic [8:0] sum;
    logic [4:0] low;

    always_comb begin
        sum = {1'h0, op_a} + {1'h0, op_b};
        low = {1'h0, op_a[3:0]} + {1'h0, op_b[3:0]};
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            insn_done <= 1'h0;
            alu_upd <= 1'h0;
            alu_hvnzc <= 5'h00;
        end else begin
            insn_done <= run & ~(slow & insn_done);
            alu_upd <= go;
            if (go) begin
                alu_hvnzc[4] <= low[4];
                alu_hvnzc[3] <= (op_a[7] == op_b[7]) && (sum[7] != op_a[7]);
                alu_hvnzc[2:0] <= {sum[7], sum[7:0] == 8'h00, sum[8]};
            end else begin
                // flag values mean nothing outside the update pulse, so keep them moving
                alu_hvnzc <= ~alu_hvnzc;
            end
        end
    end
endmodule
`default_nettype wire

// ### cpu_core_special_registers_bench.sv
// cpu_core_special_registers_bench: self-checking bench for csr_bank with a core model.
// assumes csr_pkg, csr_guard_if, csr_guard and csr_bank are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_special_registers_bench;
    localparam logic [15:0] TOP = 16'h3fff;
    localparam logic [15:0] SM = 16'h3fff;
    localparam logic [7:0] PM = 8'h7f;
    localparam logic [7:0] JM = 8'h3f;
    localparam logic [7:0] IPAT = 8'h26;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, alu_mask = 8'h00, op_a = 8'h00, op_b = 8'h00;
    logic reg_wr = 1'h0, reg_rd = 1'h0, io_wr_any = 1'h0, set_irq_insn = 1'h0;
    logic clear_irq_insn = 1'h0, bit_store_insn = 1'h0, bit_store_val = 1'h0;
    logic sp_load = 1'h0, run = 1'h0, slow = 1'h0, go = 1'h0, rd_d = 1'h0, prev;
    logic [15:0] z_ptr = 16'h0000, x_ptr = 16'h0000, y_ptr = 16'h0000;
    logic [15:0] direct_op = 16'h0000, sp_load_val = 16'h0000, stack_ptr;
    logic insn_done, alu_upd, reg_wait, bit_load_insn_val, irq_allow;
    logic key_ioreg_open, key_spm_open;
    logic [4:0] hv;
    logic [7:0] reg_rdata, cpu_flags, d, e, m, f, old, pg[8:12];
    logic [23:0] jump_addr, direct_addr, x_addr, y_addr, z_addr;
    logic [7:0] q[$];
    int n_errors = 0, n_tests = 0, n_insn = 0, n_wait = 0, cyc = 0, w0;

    always #5 clk_sys = ~clk_sys;

    csr_bank #(.PAGE_BITS(7), .JUMP_BITS(6), .SP_BITS(14), .SRAM_TOP(TOP)) dut_u (
        .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_wait,
        .io_wr_any, .insn_done, .set_irq_insn, .clear_irq_insn, .bit_store_insn,
        .bit_store_val, .alu_upd, .alu_mask, .alu_h(hv[4]), .alu_v(hv[3]), .alu_n(hv[2]),
        .alu_z(hv[1]), .alu_c(hv[0]), .z_ptr, .x_ptr, .y_ptr, .direct_op, .sp_load,
        .sp_load_val, .jump_addr, .direct_addr, .x_addr, .y_addr, .z_addr, .stack_ptr,
        .cpu_flags, .bit_load_insn_val, .irq_allow, .key_ioreg_open, .key_spm_open);

    csr_core_model model_u (.clk_sys, .rst, .run, .slow, .go, .op_a, .op_b, .insn_done,
        .alu_upd, .alu_hvnzc(hv));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        @(posedge clk_sys);
    endtask

    // the expected byte is noted here and compared by the monitor a cycle later
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'h1;
        q.push_back(exp);
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        @(posedge clk_sys);
    endtask

    // retire instructions; interrupts stay off until n have retired, then equal ex
    task automatic walk(input int n, input logic ex);
        int base;
        run <= 1'h1;
        for (int i = 0; i < 14; i++) begin
            @(negedge clk_sys);
            if (i == 0) base = n_insn;
            check(irq_allow, (n_insn - base >= n) ? ex : 1'h0);
        end
        @(posedge clk_sys);
        run <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        n_insn <= n_insn + int'(insn_done);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    always @(negedge clk_sys) begin
        if (reg_wait === 1'h1) n_wait++;
        if (rd_d) check(reg_rdata, q.pop_front());
    end

    initial begin
        void'($urandom(53546));
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        for (int a = 0; a < 16; a++) rd(4'(a), a == 13 ? TOP[7:0] : a == 14 ? TOP[15:8] : 8'h00);
        check(stack_ptr, TOP);
        for (int a = 8; a < 13; a++) begin
            pg[a] = 8'($urandom) & (a == 12 ? JM : PM);
            // junk goes only into the unimplemented bits, which must drop away
            wr(4'(a), (8'($urandom) & ~(a == 12 ? JM : PM)) | pg[a]);
            rd(4'(a), pg[a]);
        end
        z_ptr <= 16'($urandom);
        x_ptr <= 16'($urandom);
        y_ptr <= 16'($urandom);
        direct_op <= 16'($urandom);
        @(negedge clk_sys);
        check(jump_addr, {pg[12], z_ptr});
        check(direct_addr, {pg[8], direct_op});
        check(x_addr, {pg[9], x_ptr});
        check(y_addr, {pg[10], y_ptr});
        check(z_addr, {pg[11], z_ptr});
        @(posedge clk_sys);
        wr(4'hc, 8'hff);
        rd(4'hc, JM);
        for (int a = 0; a < 8; a++) begin
            if (a != 4) wr(4'(a), 8'($urandom));
            if (a != 4) rd(4'(a), 8'h00);
        end
        d = 8'($urandom);
        e = 8'($urandom);
        wr(4'hd, d);
        wr(4'he, e);
        rd(4'hd, d);
        rd(4'he, e & SM[15:8]);
        check(stack_ptr, {e, d} & SM);
        sp_load_val <= 16'($urandom);
        sp_load <= 1'h1;
        @(posedge clk_sys);
        sp_load <= 1'h0;
        @(negedge clk_sys);
        check(stack_ptr, sp_load_val & SM);
        @(posedge clk_sys);
        prev = 1'h0;
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            d[7] = IPAT[i];
            w0 = n_wait;
            wr(4'hf, d);
            check(24'(n_wait - w0), 24'(d[7] != prev));
            rd(4'hf, {d[7:5], d[2] ^ d[3], d[3:0]});
            check(irq_allow, d[7]);
            check(bit_load_insn_val, d[6]);
            prev = d[7];
        end
        for (int i = 0; i < 2; i++) begin
            bit_store_val <= i[0];
            bit_store_insn <= 1'h1;
            @(posedge clk_sys);
            bit_store_insn <= 1'h0;
            @(negedge clk_sys);
            check(bit_load_insn_val, i[0]);
            @(posedge clk_sys);
        end
        for (int i = 0; i < 8; i++) begin
            m = 8'($urandom) & 8'h2f;
            op_a <= 8'($urandom);
            op_b <= 8'($urandom);
            alu_mask <= m;
            go <= 1'h1;
            old = cpu_flags;
            @(posedge clk_sys);
            go <= 1'h0;
            @(negedge clk_sys);
            f = {2'h0, hv[4], 1'h0, hv[3:0]};
            @(negedge clk_sys);
            f = (old & ~m) | (f & m);
            f[4] = f[2] ^ f[3];
            check(cpu_flags, f);
            @(posedge clk_sys);
        end
        set_irq_insn <= 1'h1;
        @(posedge clk_sys);
        set_irq_insn <= 1'h0;
        walk(0, 1'h1);
        clear_irq_insn <= 1'h1;
        @(posedge clk_sys);
        clear_irq_insn <= 1'h0;
        @(negedge clk_sys);
        check(irq_allow, 1'h0);
        @(posedge clk_sys);
        wr(4'hf, 8'h80);
        slow <= 1'h1;
        wr(4'hd, d);
        walk(4, 1'h1);
        slow <= 1'h0;
        wr(4'hd, d);
        check(irq_allow, 1'h0);
        io_wr_any <= 1'h1;
        @(posedge clk_sys);
        io_wr_any <= 1'h0;
        @(negedge clk_sys);
        check(irq_allow, 1'h1);
        @(posedge clk_sys);
        wr(4'h4, csr_pkg::KEY_IOREG);
        check(key_ioreg_open, 1'h1);
        check(key_spm_open, 1'h0);
        rd(4'h4, 8'h01);
        walk(4, 1'h1);
        rd(4'h4, 8'h00);
        check(key_ioreg_open, 1'h0);
        wr(4'h4, csr_pkg::KEY_SPM);
        check(key_spm_open, 1'h1);
        check(key_ioreg_open, 1'h0);
        rd(4'h4, 8'h02);
        check(irq_allow, 1'h0);
        wr(4'h8, 8'h00);
        check(key_spm_open, 1'h0);
        rd(4'h4, 8'h00);
        wr(4'h4, 8'h55);
        rd(4'h4, 8'h00);
        check(irq_allow, 1'h1);
        summarize();
    end
endmodule
`default_nettype wire
